//--- rtl/oec_pkg.sv
// Package for the OUT endpoint configuration byte block.
// Assumes one 50 MHz clock and a synchronous active-high reset.
package oec_pkg;
    // Register indices on the plain register port
    localparam logic [1:0] ADDR_CFG = 2'h0;
    localparam logic [1:0] ADDR_IRQ_STAT = 2'h1;
    localparam logic [1:0] ADDR_IRQ_MASK = 2'h2;
    localparam logic [1:0] ADDR_STATUS = 2'h3;
    // Configuration byte field positions
    localparam int CFG_EN = 7;
    localparam int CFG_ISO = 6;
    localparam int CFG_TOGGLE = 5;
    localparam int CFG_DUAL = 4;
    localparam int CFG_STALL = 3;
    localparam int CFG_IE = 2;
    localparam logic [7:0] CFG_RESV_MASK = 8'h03;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // Interrupt status bit positions
    localparam int IRQ_DONE = 0;
    localparam int IRQ_STALLED = 1;
    localparam int IRQ_AUTOSTALL = 2;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    // Transaction results towards the link side
    typedef enum logic [1:0] {OEC_HS_NONE, OEC_HS_ACK, OEC_HS_NAK, OEC_HS_STALL} oec_hs_e;
endpackage

//--- rtl/oec_bufsel.sv
// Buffer selector: picks the X or Y packet buffer for each OUT data packet.
// Assumes the caller pulses i_adv once per accepted packet.
`timescale 1ns/1ps
module oec_bufsel (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_dual,
    input wire logic i_adv,
    output logic o_use_y
);
    typedef struct packed {logic y;} oec_sel_s;
    oec_sel_s s_q, s_d;

    // Alternate only in dual mode; single mode pins X so Y is never written
    always_comb
    begin
        s_d = s_q;
        if (!i_dual)
            s_d.y = 1'b0;
        else if (i_adv)
            s_d.y = ~s_q.y;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign o_use_y = s_q.y;

    a_single_x_only: assert property (@(posedge i_mclk) disable iff (i_rst)
        !i_dual |=> !o_use_y) else $error("Y buffer chosen in single mode");
    a_dual_alternate: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_dual && i_adv && $past(i_dual)) |=> (o_use_y != $past(o_use_y)))
        else $error("Dual mode did not alternate");
endmodule // oec_bufsel

//--- rtl/oec_out_ep_cfg.sv
// OUT endpoint configuration byte with buffer manager actions and interrupts.
// Assumes the link engine presents one-cycle transaction pulses on the clock.
// Assumes software keeps the reserved bits and the isochronous bit clear.
//
// Contract
// - Buffer manager flips the toggle bit after a good OUT data packet with expected PID.
// - Dual buffer bit set: X and Y buffers used alternately for OUT packets.
// - Dual buffer bit clear: only X buffer receives data, Y untouched.
// - Interrupt enable bit gates this endpoint's interrupt; clear means no interrupt.
`timescale 1ns/1ps
module oec_out_ep_cfg
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_tok_out,
    input wire logic i_tok_setup,
    input wire logic i_pkt_ok,
    input wire logic i_pid_data1,
    input wire logic i_overlong,
    output logic [7:0] o_rdata,
    output logic [1:0] o_handshake,
    output logic o_wr_x,
    output logic o_wr_y,
    output logic o_irq
);
    import oec_pkg::*;

    // All block state but the buffer selector lives in one register image; reset loads the defaults
    typedef struct packed {
        logic [7:0] cfg;
        logic [2:0] stat;
        logic [2:0] mask;
        logic [7:0] rdata;
        logic [1:0] hs;
        logic wr_x;
        logic wr_y;
        logic irq;
    } oec_state_s;

    oec_state_s s_q, s_d;
    // Decode results shared by the next-state logic and the checks
    logic use_y;
    logic accept;
    logic stall_hit;
    logic [2:0] ev;

    // Read value of a register index
    function automatic logic [7:0] rd_mux(input logic [1:0] a, input oec_state_s s,
                                          input logic y);
        case (a)
            ADDR_CFG: rd_mux = s.cfg & ~CFG_RESV_MASK;
            ADDR_IRQ_STAT: rd_mux = {5'h00, s.stat};
            ADDR_IRQ_MASK: rd_mux = {5'h00, s.mask};
            ADDR_STATUS: rd_mux = {7'h00, y};
            default: rd_mux = 8'h00;
        endcase
    endfunction

    // Register strobe decode, used by the next-state logic and the checks
    function automatic logic reg_hit(input logic strobe, input logic [1:0] a,
                                     input logic [1:0] idx);
        reg_hit = strobe && (a == idx);
    endfunction

    // Selector state sits apart so its alternation can be checked on its own
    oec_bufsel u_sel (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_dual(s_q.cfg[CFG_DUAL]),
        .i_adv(accept),
        .o_use_y(use_y)
    );

    // Transaction decode; setup stages bypass stall so a clear request can land
    always_comb
    begin
        stall_hit = s_q.cfg[CFG_EN] && i_tok_out && s_q.cfg[CFG_STALL];
        accept = s_q.cfg[CFG_EN] && !s_q.cfg[CFG_ISO] && i_tok_out && i_pkt_ok
                 && !s_q.cfg[CFG_STALL] && (i_pid_data1 == s_q.cfg[CFG_TOGGLE]);
        // Events feed the sticky status bits below
        ev = '0;
        ev[IRQ_DONE] = accept || (s_q.cfg[CFG_EN] && i_tok_setup && i_pkt_ok);
        ev[IRQ_STALLED] = stall_hit;
        ev[IRQ_AUTOSTALL] = s_q.cfg[CFG_EN] && i_overlong;
    end

    // Next state: register writes, buffer manager updates, events
    always_comb
    begin
        s_d = s_q;
        if (reg_hit(i_wr, i_addr, ADDR_CFG))
            s_d.cfg = i_wdata & ~CFG_RESV_MASK;
        if (reg_hit(i_wr, i_addr, ADDR_IRQ_MASK))
            s_d.mask = i_wdata[2:0];
        // Hardware updates follow the write so they win a same-cycle collision
        if (accept)
            s_d.cfg[CFG_TOGGLE] = ~s_q.cfg[CFG_TOGGLE];
        if (s_q.cfg[CFG_EN] && i_overlong)
            s_d.cfg[CFG_STALL] = 1'b1;
        // Write-one-to-clear, but a same-cycle event wins
        if (reg_hit(i_wr, i_addr, ADDR_IRQ_STAT))
            s_d.stat = s_q.stat & ~i_wdata[2:0];
        s_d.stat = s_d.stat | ev;
        s_d.rdata = i_rd ? rd_mux(i_addr, s_q, use_y) : 8'h00;
        // Setup first, so a stalled control pipe can still take its clear request
        // A NAK is never made here; flow control belongs to the link engine
        if (i_tok_setup && s_q.cfg[CFG_EN])
            s_d.hs = i_pkt_ok ? OEC_HS_ACK : OEC_HS_NONE;
        else if (stall_hit)
            s_d.hs = OEC_HS_STALL;
        else if (i_tok_out && s_q.cfg[CFG_EN])
            s_d.hs = (i_pkt_ok && !s_q.cfg[CFG_ISO]) ? OEC_HS_ACK : OEC_HS_NONE;
        else
            s_d.hs = OEC_HS_NONE;
        // The selector lags a dual-bit change by one cycle, so gate Y with the bit itself
        s_d.wr_x = accept && !(use_y && s_q.cfg[CFG_DUAL]);
        s_d.wr_y = accept && use_y && s_q.cfg[CFG_DUAL];
        // Mask and per-endpoint enable both gate the line, taken from the next image
        s_d.irq = s_d.cfg[CFG_IE] && |(s_d.stat & s_d.mask);
    end

    // One register stage for the whole image; reset is synchronous
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            s_q <= '0;
            s_q.cfg <= CFG_RESET;
            s_q.stat <= IRQ_RESET;
        end
        else
            s_q <= s_d;
    end

    // Every output comes straight from the register image
    assign o_rdata = s_q.rdata;
    assign o_handshake = s_q.hs;
    assign o_wr_x = s_q.wr_x;
    assign o_wr_y = s_q.wr_y;
    assign o_irq = s_q.irq;

    // Checks on the buffer manager side; all on the one clock, quiet during reset
    // Toggle flips on every accepted packet, even against a software write
    a_toggle_flip: assert property (@(posedge i_mclk) disable iff (i_rst)
        accept |=> (s_q.cfg[CFG_TOGGLE] != $past(s_q.cfg[CFG_TOGGLE])))
        else $error("Toggle did not flip");
    a_toggle_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
        !(accept || reg_hit(i_wr, i_addr, ADDR_CFG)) |=> $stable(s_q.cfg[CFG_TOGGLE]))
        else $error("Toggle moved without a packet");
    a_pid_mismatch: assert property (@(posedge i_mclk) disable iff (i_rst)
        (s_q.cfg[CFG_EN] && !s_q.cfg[CFG_ISO] && !s_q.cfg[CFG_STALL] && i_tok_out
         && i_pkt_ok && (i_pid_data1 != s_q.cfg[CFG_TOGGLE]))
        |=> (o_handshake == OEC_HS_ACK && !o_wr_x && !o_wr_y))
        else $error("Repeated packet was stored");
    a_ack_store: assert property (@(posedge i_mclk) disable iff (i_rst)
        accept |=> (o_handshake == OEC_HS_ACK && (o_wr_x || o_wr_y)))
        else $error("Accepted packet not stored");

    // Buffer choice: single mode stores only in X, dual mode follows the selector
    a_single_no_y: assert property (@(posedge i_mclk) disable iff (i_rst)
        !s_q.cfg[CFG_DUAL] |=> !o_wr_y) else $error("Y written in single mode");
    a_single_x_store: assert property (@(posedge i_mclk) disable iff (i_rst)
        (accept && !s_q.cfg[CFG_DUAL]) |=> (o_wr_x && !o_wr_y))
        else $error("Single mode packet not in X");
    a_dual_alt: assert property (@(posedge i_mclk) disable iff (i_rst)
        (o_wr_x && s_q.cfg[CFG_DUAL] && $past(s_q.cfg[CFG_DUAL])) |-> !o_wr_y)
        else $error("Both buffers written");
    a_dual_next_y: assert property (@(posedge i_mclk) disable iff (i_rst)
        (accept && s_q.cfg[CFG_DUAL] && use_y) |=> (o_wr_y && !o_wr_x))
        else $error("Dual mode skipped the Y buffer");

    // Interrupt line follows enable, mask and status with no extra lag
    a_irq_gated: assert property (@(posedge i_mclk) disable iff (i_rst)
        !s_q.cfg[CFG_IE] |-> !o_irq) else $error("Interrupt while disabled");
    a_irq_level: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_irq == (s_q.cfg[CFG_IE] && |(s_q.stat & s_q.mask)))
        else $error("Interrupt level out of step");
    a_stat_set_wins: assert property (@(posedge i_mclk) disable iff (i_rst)
        (ev != 3'h0) |=> ((s_q.stat & $past(ev)) == $past(ev)))
        else $error("Event lost against a clear");
    a_stat_clear: assert property (@(posedge i_mclk) disable iff (i_rst)
        (reg_hit(i_wr, i_addr, ADDR_IRQ_STAT) && ev == 3'h0)
        |=> ((s_q.stat & $past(i_wdata[2:0])) == 3'h0))
        else $error("Status bit not cleared");

    // Reserved bits never hold or read back a one
    a_resv_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
        (s_q.cfg & CFG_RESV_MASK) == 8'h00) else $error("Reserved bits set");
    a_resv_read: assert property (@(posedge i_mclk) disable iff (i_rst)
        reg_hit(i_rd, i_addr, ADDR_CFG) |=> (o_rdata[1:0] == 2'h0))
        else $error("Reserved bits read back");

    // Stall: OUT answered with a stall, setup always taken, only software clears
    a_stall_answer: assert property (@(posedge i_mclk) disable iff (i_rst)
        (stall_hit && !i_tok_setup) |=> o_handshake == OEC_HS_STALL)
        else $error("Stall not answered");
    a_stall_no_store: assert property (@(posedge i_mclk) disable iff (i_rst)
        stall_hit |=> (!o_wr_x && !o_wr_y))
        else $error("Stalled packet was stored");
    a_setup_accept: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_tok_setup && i_pkt_ok && s_q.cfg[CFG_EN]) |=> o_handshake == OEC_HS_ACK)
        else $error("Setup not accepted");
    a_setup_no_stall: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_tok_setup && s_q.cfg[CFG_EN]) |=> (o_handshake != OEC_HS_STALL))
        else $error("Setup stage was stalled");
    a_autostall_set: assert property (@(posedge i_mclk) disable iff (i_rst)
        (s_q.cfg[CFG_EN] && i_overlong) |=> s_q.cfg[CFG_STALL] && s_q.stat[IRQ_AUTOSTALL])
        else $error("Overlong write did not stall");
    a_stall_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
        (s_q.cfg[CFG_STALL] && !reg_hit(i_wr, i_addr, ADDR_CFG)) |=> s_q.cfg[CFG_STALL])
        else $error("Stall bit dropped by hardware");

    // Isochronous select leaves this byte's handshakes and stores silent
    a_iso_quiet: assert property (@(posedge i_mclk) disable iff (i_rst)
        (s_q.cfg[CFG_ISO] && !s_q.cfg[CFG_STALL] && i_tok_out && !i_tok_setup)
        |=> (o_handshake == OEC_HS_NONE && !o_wr_x && !o_wr_y))
        else $error("Isochronous packet answered");
endmodule // oec_out_ep_cfg

//--- bench/oec_host_model.sv
// Host model: sends OUT, setup and overlong events towards the endpoint.
// Assumes the bench calls xfer from one thread, one event at a time.
`timescale 1ns/1ps
module oec_host_model (
    input wire logic i_mclk,
    output logic o_tok_out,
    output logic o_tok_setup,
    output logic o_pkt_ok,
    output logic o_pid_data1,
    output logic o_overlong
);
    // Idle link at time zero
    initial {o_tok_out, o_tok_setup, o_pkt_ok, o_pid_data1, o_overlong} = 5'h0;
    // One-cycle event; kind 0 OUT, 1 setup, 2 overlong
    task automatic xfer(input int kind, input logic pid);
        @(posedge i_mclk);
        o_tok_out <= (kind == 0);
        o_tok_setup <= (kind == 1);
        o_overlong <= (kind == 2);
        o_pkt_ok <= 1'b1;
        o_pid_data1 <= pid;
        @(posedge i_mclk);
        {o_tok_out, o_tok_setup, o_overlong} <= 3'h0;
        o_pkt_ok <= 1'b0; // Released qualifiers flip so stale values never look valid
        o_pid_data1 <= ~pid;
        #1;
    endtask
endmodule // oec_host_model

//--- bench/tb.sv
// Bench for the OUT endpoint configuration byte block.
// Assumes one 50 MHz clock and the host model on the link side.
`timescale 1ns/1ps
module tb;
    import oec_pkg::*;
    typedef struct {logic [7:0] c; logic p; logic [3:0] r; logic [7:0] e;} oec_row_s;
    logic i_mclk, i_rst, i_wr, i_rd, t_out, t_set, ok, pid, ovl;
    logic [1:0] i_addr;
    logic [7:0] i_wdata;
    logic [7:0] o_rdata;
    logic [1:0] o_handshake;
    logic o_wr_x, o_wr_y, o_irq;
    int failures = 0;
    int cmp_count = 0;
    oec_row_s rows [7];
    oec_host_model u_oec_host_model (.i_mclk(i_mclk), .o_tok_out(t_out),
        .o_tok_setup(t_set), .o_pkt_ok(ok), .o_pid_data1(pid), .o_overlong(ovl));
    oec_out_ep_cfg u_oec_out_ep_cfg (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_tok_out(t_out),
        .i_tok_setup(t_set), .i_pkt_ok(ok), .i_pid_data1(pid), .i_overlong(ovl),
        .o_rdata(o_rdata), .o_handshake(o_handshake), .o_wr_x(o_wr_x),
        .o_wr_y(o_wr_y), .o_irq(o_irq));
    // 20 ns clock
    initial
    begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e)
        begin
            failures++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge i_mclk);
        {i_rd, i_addr} <= {1'b1, a};
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, e);
    endtask
    task automatic end_sim();
        $display("failures=%0d cmp_count=%0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Watchdog well past the expected run length
    initial
    begin
        repeat (5000) @(posedge i_mclk);
        failures++;
        end_sim();
    end
    // Rows: cfg, pid, {handshake, x, y}, cfg after
    initial
    begin
        rows = '{'{8'h90, 0, 4'h6, 8'hb0}, '{8'hb0, 1, 4'h5, 8'h90},
                 '{8'h90, 0, 4'h6, 8'hb0}, '{8'h80, 0, 4'h6, 8'ha0},
                 '{8'ha0, 0, 4'h4, 8'ha0}, '{8'h88, 0, 4'hc, 8'h88},
                 '{8'hc0, 0, 4'h0, 8'hc0}};
        {i_rst, i_wr, i_rd, i_addr, i_wdata} = {1'b1, 12'h0};
        repeat (12) @(posedge i_mclk);
        i_rst <= 1'b0;
        #1 chk({o_handshake, o_wr_x, o_wr_y, o_irq}, 8'h0);
        rd(ADDR_CFG, CFG_RESET);
        foreach (rows[i])
        begin
            wr(ADDR_CFG, rows[i].c);
            u_oec_host_model.xfer(0, rows[i].p);
            chk({o_handshake, o_wr_x, o_wr_y}, rows[i].r);
            rd(ADDR_CFG, rows[i].e);
        end
        rd(ADDR_IRQ_STAT, 8'h03);
        wr(ADDR_CFG, 8'h87);
        rd(ADDR_CFG, 8'h84);
        wr(ADDR_IRQ_MASK, 8'h01);
        repeat (2) @(posedge i_mclk);
        #1 chk(o_irq, 1);
        wr(ADDR_CFG, 8'h80);
        repeat (2) @(posedge i_mclk);
        #1 chk(o_irq, 0);
        wr(ADDR_IRQ_STAT, 8'h07);
        rd(ADDR_IRQ_STAT, 8'h00);
        wr(ADDR_CFG, 8'h88);
        u_oec_host_model.xfer(1, 0);
        chk(o_handshake, OEC_HS_ACK);
        wr(ADDR_CFG, 8'h80);
        u_oec_host_model.xfer(2, 0);
        rd(ADDR_CFG, 8'h88);
        rd(ADDR_IRQ_STAT, 8'h05);
        // Dual mode stores in X first, then the status bit points at Y
        wr(ADDR_CFG, 8'h90);
        u_oec_host_model.xfer(0, 0);
        chk({o_handshake, o_wr_x, o_wr_y}, 4'h6);
        rd(ADDR_STATUS, 8'h01);
        wr(ADDR_CFG, 8'h80);
        rd(ADDR_STATUS, 8'h00);
        // Mid-run reset: one edge brings everything back to defaults
        @(posedge i_mclk);
        i_rst <= 1'b1;
        @(posedge i_mclk);
        i_rst <= 1'b0;
        #1 chk({o_handshake, o_wr_x, o_wr_y, o_irq}, 8'h0);
        rd(ADDR_CFG, CFG_RESET);
        rd(ADDR_IRQ_STAT, 8'h00);
        end_sim();
    end
endmodule // tb
